//--- design/spddr_pkg.sv
// package: constants, carriers and state of the split-port ddr sram device
package spddr_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int SP_AW = 21;
    localparam int SP_DW = 18;
    localparam int SP_BW = 2;
    localparam int SP_FIFO_DEPTH = 8;
    localparam int SP_PAW = 8;
    localparam int SP_LANE0_MSB = 8;
    localparam int SP_LANE1_LSB = 9;

    // ************************************************************
    // register map and fields
    // ************************************************************
    localparam logic [7:0] SP_REG_STATUS = 8'h00;
    localparam logic [7:0] SP_REG_CTRL = 8'h04;
    localparam logic [7:0] SP_REG_MADDR = 8'h08;
    localparam logic [7:0] SP_REG_MDATA = 8'h0C;
    localparam logic [7:0] SP_REG_RDCNT = 8'h10;
    localparam int SP_ST_TERM = 0;
    localparam int SP_ST_PLL = 1;
    localparam int SP_ST_OVF = 2;
    localparam int SP_ST_FEMPTY = 3;
    localparam int SP_CTRL_HOLD = 0;

    // ************************************************************
    // reset values and counts
    // ************************************************************
    localparam logic SP_TERM_RST = 1'h1;
    localparam logic [1:0] SP_TERM_LATCH_CYC = 2'h3;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic k;
        logic kn;
        logic wps_n;
        logic rps_n;
        logic [SP_BW-1:0] bws_n;
        logic [SP_AW-1:0] addr;
        logic [SP_DW-1:0] d;
        logic pll_dis_n;
        logic term_sel;
    } spddr_pins_t;

    typedef struct packed {
        logic [SP_AW:0] waddr;
        logic [SP_DW-1:0] data;
        logic [SP_BW-1:0] bws_n;
    } spddr_wword_t;

    typedef struct packed {
        logic vld;
        logic [SP_AW-1:0] addr;
    } spddr_rreq_t;

    typedef struct packed {
        spddr_pins_t s1;
        spddr_pins_t s2;
        logic k_d;
        logic wr_act;
        logic [SP_DW-1:0] wr_d0;
        logic [SP_BW-1:0] wr_b0;
        logic push_v;
        spddr_wword_t push_w;
        logic pend_v;
        spddr_wword_t pend_w;
        spddr_rreq_t rd_p1;
        spddr_rreq_t rd_p2;
        logic [SP_AW-1:0] rd_cur;
        logic rd_w1;
        logic [SP_DW-1:0] q;
        logic q_oe;
        logic rvld;
        logic ck;
        logic ckn;
        logic kn_d;
        logic term;
        logic term_done;
        logic [1:0] term_cnt;
        logic ovf;
        logic hold;
        logic [SP_AW:0] maddr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [15:0] rdcnt;
    } spddr_st_t;

    // byte lane merge, low select writes the lane
    function automatic logic [SP_DW-1:0] sp_merge(
        input logic [SP_DW-1:0] old_w,
        input logic [SP_DW-1:0] new_w,
        input logic [SP_BW-1:0] bws_n
    );
        logic [SP_DW-1:0] r;
        r = old_w;
        if (!bws_n[0]) begin
            r[SP_LANE0_MSB:0] = new_w[SP_LANE0_MSB:0];
        end
        if (!bws_n[1]) begin
            r[SP_DW-1:SP_LANE1_LSB] = new_w[SP_DW-1:SP_LANE1_LSB];
        end
        return r;
    endfunction

endpackage

//--- design/spddr_sram_dev.sv
// split-port ddr sram device: pin logic, write fifo, array and apb registers
`timescale 1ns/1ps

// ************************************************************
// write word fifo
// ************************************************************
module spddr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW:0] wp;
        logic [PW:0] rp;
    } spddr_fifo_st_t;
    spddr_fifo_st_t st;
    spddr_fifo_st_t nxt;
    logic [W-1:0] mem [0:DEPTH-1];
    logic full;
    logic empty;

    assign full = (st.wp[PW] != st.rp[PW]) && (st.wp[PW-1:0] == st.rp[PW-1:0]);
    assign empty = (st.wp == st.rp);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[st.rp[PW-1:0]];

    always_comb begin
        nxt = st;
        if (in_valid && !full) begin
            nxt.wp = st.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            nxt.rp = st.rp + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem[st.wp[PW-1:0]] <= in_data;
        end
    end
endmodule

// ************************************************************
// device top
// ************************************************************
module spddr_sram_dev
    import spddr_pkg::*;
#(
    parameter int MEM_AW = SP_AW,
    parameter int FIFO_DEPTH = SP_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic k,
    input wire logic k_n,
    input wire logic [SP_AW-1:0] addr,
    input wire logic [SP_DW-1:0] d,
    input wire logic write_port_sel_n,
    input wire logic read_port_sel_n,
    input wire logic [SP_BW-1:0] byte_lane_write_sel_n,
    input wire logic pll_disable_n,
    input wire logic termination_range_sel,
    output logic [SP_DW-1:0] q,
    output logic q_oe,
    output logic echo_clk,
    output logic echo_clk_n,
    output logic read_valid_flag,
    output logic term_high_range,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SP_PAW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [SP_DW-1:0] mem [0:(2**(MEM_AW+1))-1];
    spddr_st_t st;
    spddr_st_t nxt;
    spddr_pins_t pins_in;
    spddr_wword_t fo;
    spddr_rreq_t due;
    logic k_rise;
    logic kn_rise;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic drain;
    logic bd_wr;
    logic setup;
    logic acc;
    logic ovf_clr;
    logic [SP_DW-1:0] rd_word0;
    logic [SP_DW-1:0] rd_word1;
    logic [SP_DW-1:0] drain_old;

    function automatic logic [MEM_AW:0] mem_idx(input logic [SP_AW:0] a);
        return a[MEM_AW:0];
    endfunction

    function automatic logic reg_mapped(input logic [SP_PAW-1:0] a);
        return (a == SP_REG_STATUS) || (a == SP_REG_CTRL) ||
            (a == SP_REG_MADDR) || (a == SP_REG_MDATA) ||
            (a == SP_REG_RDCNT);
    endfunction

    // ************************************************************
    // pin sampling and edge detection
    // ************************************************************
    assign pins_in = '{k: k, kn: k_n, wps_n: write_port_sel_n,
        rps_n: read_port_sel_n, bws_n: byte_lane_write_sel_n,
        addr: addr, d: d, pll_dis_n: pll_disable_n,
        term_sel: termination_range_sel};
    assign k_rise = st.s2.k && !st.k_d;
    assign kn_rise = st.s2.kn && !st.kn_d;
    assign due = st.s2.pll_dis_n ? st.rd_p2 : st.rd_p1;
    assign rd_word0 = mem[mem_idx({due.addr, 1'b0})];
    assign rd_word1 = mem[mem_idx({st.rd_cur, 1'b1})];

    // ************************************************************
    // write fifo and array port
    // ************************************************************
    spddr_fifo #(
        .W($bits(spddr_wword_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_wfifo (
        .clk(mclk),
        .reset(reset),
        .in_valid(st.push_v),
        .in_ready(fifo_in_ready),
        .in_data(st.push_w),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fo)
    );

    assign setup = psel && !penable;
    assign acc = psel && penable && st.pready;
    assign bd_wr = acc && pwrite && (paddr == SP_REG_MDATA);
    assign ovf_clr = acc && pwrite && (paddr == SP_REG_STATUS) &&
        pwdata[SP_ST_OVF];
    assign fifo_out_ready = !st.hold && !bd_wr;
    assign drain = fifo_out_valid && fifo_out_ready;
    assign drain_old = mem[mem_idx(fo.waddr)];

    always_ff @(posedge mclk) begin
        if (bd_wr) begin
            mem[mem_idx(st.maddr)] <= pwdata[SP_DW-1:0];
        end else if (drain) begin
            mem[mem_idx(fo.waddr)] <= sp_merge(drain_old, fo.data, fo.bws_n);
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt = st;
        nxt.s1 = pins_in;
        nxt.s2 = st.s1;
        nxt.k_d = st.s2.k;
        nxt.kn_d = st.s2.kn;
        nxt.ck = st.s2.k;
        nxt.ckn = st.s2.kn;
        nxt.push_v = 1'b0;
        if (k_rise) begin
            nxt.wr_act = !st.s2.wps_n;
            nxt.wr_d0 = st.s2.d;
            nxt.wr_b0 = st.s2.bws_n;
        end
        if (kn_rise && st.wr_act) begin
            nxt.wr_act = 1'b0;
            nxt.push_v = 1'b1;
            nxt.push_w = '{waddr: {st.s2.addr, 1'b0}, data: st.wr_d0,
                bws_n: st.wr_b0};
            nxt.pend_v = 1'b1;
            nxt.pend_w = '{waddr: {st.s2.addr, 1'b1}, data: st.s2.d,
                bws_n: st.s2.bws_n};
        end else if (st.pend_v) begin
            nxt.push_v = 1'b1;
            nxt.push_w = st.pend_w;
            nxt.pend_v = 1'b0;
        end
        if (k_rise) begin
            nxt.rd_p1 = '{vld: !st.s2.rps_n, addr: st.s2.addr};
            nxt.rd_p2 = st.rd_p1;
            nxt.q_oe = due.vld;
            nxt.rvld = due.vld;
            nxt.rd_w1 = due.vld;
            nxt.rd_cur = due.addr;
            nxt.q = due.vld ? rd_word0 : '0;
            if (due.vld) begin
                nxt.rdcnt = st.rdcnt + 16'h0001;
            end
        end else if (kn_rise && st.rd_w1) begin
            nxt.q = rd_word1;
            nxt.rd_w1 = 1'b0;
        end
        if (!st.term_done) begin
            if (st.term_cnt == SP_TERM_LATCH_CYC) begin
                nxt.term = st.s2.term_sel;
                nxt.term_done = 1'b1;
            end else begin
                nxt.term_cnt = st.term_cnt + 2'h1;
            end
        end
        // overflow: set wins over clear
        nxt.ovf = (st.ovf && !ovf_clr) || (st.push_v && !fifo_in_ready);
        // apb slave
        nxt.pready = setup;
        nxt.pslverr = setup && !reg_mapped(paddr);
        if (setup) begin
            case (paddr)
                SP_REG_STATUS: begin
                    nxt.prdata = '0;
                    nxt.prdata[SP_ST_TERM] = st.term;
                    nxt.prdata[SP_ST_PLL] = st.s2.pll_dis_n;
                    nxt.prdata[SP_ST_OVF] = st.ovf;
                    nxt.prdata[SP_ST_FEMPTY] = !fifo_out_valid;
                end
                SP_REG_CTRL: nxt.prdata = {31'h0, st.hold};
                SP_REG_MADDR: nxt.prdata = {10'h000, st.maddr};
                SP_REG_MDATA: begin
                    nxt.prdata = {14'h0000, mem[mem_idx(st.maddr)]};
                end
                SP_REG_RDCNT: nxt.prdata = {16'h0000, st.rdcnt};
                default: nxt.prdata = '0;
            endcase
        end
        if (acc && pwrite) begin
            case (paddr)
                SP_REG_CTRL: nxt.hold = pwdata[SP_CTRL_HOLD];
                SP_REG_MADDR: nxt.maddr = pwdata[SP_AW:0];
                default: nxt.hold = st.hold;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
            st.term <= SP_TERM_RST;
        end else begin
            st <= nxt;
        end
    end

    assign q = st.q;
    assign q_oe = st.q_oe;
    assign echo_clk = st.ck;
    assign echo_clk_n = st.ckn;
    assign read_valid_flag = st.rvld;
    assign term_high_range = st.term;
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_wr_cmd;
        kn_rise && st.wr_act;
    endsequence
    sequence s_wr_pair;
        ##1 (st.push_v && !st.push_w.waddr[0])
        ##1 (st.push_v && st.push_w.waddr[0]);
    endsequence

    property p_wr_pair;
        s_wr_cmd |-> s_wr_pair;
    endproperty
    a_wr_pair: assert property (p_wr_pair)
        else $error("write burst not two words");
    property p_wr_start;
        k_rise && !st.s2.wps_n |=> st.wr_act && st.wr_d0 == $past(st.s2.d);
    endproperty
    a_wr_start: assert property (p_wr_start)
        else $error("write start missed");
    property p_wr_ignore;
        k_rise && st.s2.wps_n |=> !st.wr_act;
    endproperty
    a_wr_ignore: assert property (p_wr_ignore)
        else $error("deselected write pushed");
    property p_bws_carry;
        s_wr_cmd |=> st.push_w.bws_n == $past(st.wr_b0)
            ##1 st.push_w.bws_n == $past(st.s2.bws_n, 2);
    endproperty
    a_bws_carry: assert property (p_bws_carry)
        else $error("byte selects not carried");
    property p_lane;
        drain && fo.bws_n == 2'h2 |-> sp_merge(drain_old, fo.data,
            fo.bws_n) == {drain_old[17:9], fo.data[8:0]};
    endproperty
    a_lane: assert property (p_lane)
        else $error("byte lane mapping wrong");
    property p_waddr;
        s_wr_cmd |=> st.push_w.waddr[SP_AW:1] == $past(st.s2.addr);
    endproperty
    a_waddr: assert property (p_waddr)
        else $error("write address not from k_n edge");
    property p_rd_start;
        k_rise && !st.s2.rps_n |=> st.rd_p1.vld &&
            st.rd_p1.addr == $past(st.s2.addr);
    endproperty
    a_rd_start: assert property (p_rd_start)
        else $error("read command missed");
    property p_rd_ignore;
        k_rise && st.s2.rps_n |=> !st.rd_p1.vld;
    endproperty
    a_rd_ignore: assert property (p_rd_ignore)
        else $error("deselected read taken");
    property p_word1;
        kn_rise && st.rd_w1 && !k_rise |=> st.q == $past(rd_word1) && st.q_oe;
    endproperty
    a_word1: assert property (p_word1)
        else $error("second word wrong");
    property p_float;
        $fell(st.q_oe) |-> $past(k_rise) && !$past(st.rd_w1);
    endproperty
    a_float: assert property (p_float)
        else $error("output floated mid burst");
    property p_valid;
        $rose(st.rvld) |-> $rose(st.ck) && st.q_oe;
    endproperty
    a_valid: assert property (p_valid)
        else $error("valid flag not with echo clock");
    property p_term;
        st.term_done |=> st.term_done && $stable(st.term);
    endproperty
    a_term: assert property (p_term)
        else $error("termination range changed");
    property p_echo;
        k_rise |=> $rose(st.ck);
    endproperty
    a_echo: assert property (p_echo)
        else $error("echo clock does not follow k");
    property p_lat1;
        k_rise && !st.s2.pll_dis_n && st.rd_p1.vld |=> st.q_oe &&
            st.rd_cur == $past(st.rd_p1.addr);
    endproperty
    a_lat1: assert property (p_lat1)
        else $error("pll off latency wrong");
    property p_lat2;
        k_rise && st.s2.pll_dis_n && st.rd_p2.vld |=> st.q_oe && st.rvld &&
            st.q == $past(rd_word0);
    endproperty
    a_lat2: assert property (p_lat2)
        else $error("pll on latency wrong");
endmodule

//--- tb/spddr_ctrl_model.sv
// memory controller model driving the device link pins
`timescale 1ns/1ps

module spddr_ctrl_model
    import spddr_pkg::*;
(
    input wire logic mclk,
    output logic k,
    output logic k_n,
    output logic [SP_AW-1:0] addr,
    output logic [SP_DW-1:0] d,
    output logic write_port_sel_n,
    output logic read_port_sel_n,
    output logic [SP_BW-1:0] byte_lane_write_sel_n,
    output logic pll_disable_n,
    output logic termination_range_sel
);
    // ************************************************************
    // link clock and pin state
    // ************************************************************
    logic run = 1'b0;
    logic [2:0] ph = 3'h0;
    int kcnt = 0;
    int cmd_k = 0;
    spddr_pins_t p;

    initial begin
        p = '0;
        p.wps_n = 1'b1;
        p.rps_n = 1'b1;
        p.bws_n = 2'h3;
        p.pll_dis_n = 1'b1;
    end

    always_comb begin
        k = run & ~ph[2];
        k_n = run & ph[2];
        addr = p.addr;
        d = p.d;
        write_port_sel_n = p.wps_n;
        read_port_sel_n = p.rps_n;
        byte_lane_write_sel_n = p.bws_n;
        pll_disable_n = p.pll_dis_n;
        termination_range_sel = p.term_sel;
    end

    always @(posedge mclk) begin
        if (run) begin
            ph <= ph + 3'h1;
            if (ph == 3'h7) begin
                kcnt <= kcnt + 1;
            end
        end
    end

    // ************************************************************
    // command tasks
    // ************************************************************
    task automatic to_ph(input logic [2:0] v);
        @(posedge mclk);
        while (ph !== v) begin
            @(posedge mclk);
        end
    endtask

    task automatic start();
        @(posedge mclk);
        run <= 1'b1;
    endtask

    task automatic mode(input logic pll_n, input logic term);
        @(posedge mclk);
        p.pll_dis_n <= pll_n;
        p.term_sel <= term;
    endtask

    // one k cycle of commands
    task automatic cyc(input logic rd, input logic wr,
        input logic [SP_AW-1:0] ra, input logic [SP_AW-1:0] wa,
        input logic [SP_DW-1:0] d0, input logic [SP_DW-1:0] d1,
        input logic [1:0] b0, input logic [1:0] b1);
        to_ph(3'h5);
        cmd_k = kcnt + 1;
        p.rps_n <= ~rd;
        p.wps_n <= ~wr;
        p.addr <= ra;
        p.d <= d0;
        p.bws_n <= b0;
        to_ph(3'h1);
        p.addr <= wa;
        p.d <= d1;
        p.bws_n <= b1;
    endtask

    // deselected cycles, released lines toggle
    task automatic idle(input int n);
        repeat (n) begin
            to_ph(3'h5);
            p.rps_n <= 1'b1;
            p.wps_n <= 1'b1;
            p.addr <= ~p.addr;
            p.d <= ~p.d;
            to_ph(3'h1);
            p.addr <= ~p.addr;
            p.d <= ~p.d;
        end
    endtask
endmodule

//--- tb/test_split_port_ddr_sram_interface.sv
// self-checking bench of the split-port ddr sram device
`timescale 1ns/1ps

module test_split_port_ddr_sram_interface
    import spddr_pkg::*;
;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic k, k_n, wsel_n, rsel_n, pll_n, term_sel;
    logic [SP_AW-1:0] addr;
    logic [SP_DW-1:0] d;
    logic [SP_BW-1:0] bsel_n;
    logic [SP_DW-1:0] q;
    logic q_oe, echo_clk, echo_clk_n, read_valid_flag, term_hi;
    logic [31:0] prdata, rv;
    logic pready, pslverr, re;
    int err_count = 0;
    int n_compared = 0;
    int tcnt = 0;
    logic ek_d = 1'b0;
    logic ekn_d = 1'b0;
    int cap_k[$];
    logic [SP_DW-1:0] cap_q[$];

    spddr_ctrl_model m (.mclk(mclk), .k(k), .k_n(k_n), .addr(addr), .d(d),
        .write_port_sel_n(wsel_n), .read_port_sel_n(rsel_n),
        .byte_lane_write_sel_n(bsel_n), .pll_disable_n(pll_n),
        .termination_range_sel(term_sel));

    spddr_sram_dev #(.MEM_AW(6), .FIFO_DEPTH(SP_FIFO_DEPTH)) dut (
        .mclk(mclk), .reset(reset), .k(k), .k_n(k_n),
        .addr(addr), .d(d), .write_port_sel_n(wsel_n),
        .read_port_sel_n(rsel_n), .byte_lane_write_sel_n(bsel_n),
        .pll_disable_n(pll_n), .termination_range_sel(term_sel),
        .q(q), .q_oe(q_oe), .echo_clk(echo_clk), .echo_clk_n(echo_clk_n),
        .read_valid_flag(read_valid_flag), .term_high_range(term_hi),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        forever #25 mclk = ~mclk;
    end

    // ************************************************************
    // timeout, read capture, checks
    // ************************************************************
    always @(posedge mclk) begin
        tcnt++;
        if (tcnt == 8000) begin
            err_count++;
            end_sim();
        end
    end

    // one word per echo edge while valid
    always @(posedge mclk) begin
        ek_d <= echo_clk;
        ekn_d <= echo_clk_n;
        if (read_valid_flag === 1'b1 && ((echo_clk && !ek_d) ||
            (echo_clk_n && !ekn_d))) begin
            cap_q.push_back(q);
            cap_k.push_back(m.kcnt);
        end
    end

    task automatic chk(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic exp2(input int i, input int kk,
        input logic [SP_DW-1:0] e0, input logic [SP_DW-1:0] e1);
        chk(cap_q.size() > i + 1, "burst words missing");
        if (cap_q.size() > i + 1) begin
            chk(cap_k[i] == kk && cap_k[i + 1] == kk, "read latency");
            chk(cap_q[i] === e0, "first read word");
            chk(cap_q[i + 1] === e1, "second read word");
        end
    endtask

    task automatic rd1(input logic [SP_AW-1:0] a, input int lat,
        input logic [SP_DW-1:0] e0, input logic [SP_DW-1:0] e1);
        int c;
        cap_q.delete();
        cap_k.delete();
        m.cyc(1'b1, 1'b0, a, 21'h0, 18'h0, 18'h0, 2'h3, 2'h3);
        c = m.cmd_k;
        m.idle(lat + 2);
        exp2(0, c + lat, e0, e1);
        chk(cap_q.size() == 2, "burst length");
        chk(q_oe === 1'b0 && read_valid_flag === 1'b0, "q released");
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_wr_rd();
        m.cyc(1'b0, 1'b1, 21'h0, 21'h3, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0);
        m.idle(2);
        rd1(21'h3, 2, 18'h2A5A5, 18'h15A5A);
        apb(1'b1, SP_REG_MADDR, 32'h7, rv, re);
        apb(1'b0, SP_REG_MDATA, 32'h0, rv, re);
        chk(rv === 32'h15A5A, "second word of entry");
        apb(1'b0, SP_REG_RDCNT, 32'h0, rv, re);
        chk(rv === 32'h1, "burst count");
        chk(re === 1'b0, "mapped read refused");
        $display("test wr_rd done");
    endtask

    task automatic t_lanes();
        m.cyc(1'b0, 1'b1, 21'h0, 21'h3, 18'h3FFFF, 18'h0, 2'h2, 2'h1);
        m.idle(2);
        rd1(21'h3, 2, 18'h2A5FF, 18'h0005A);
        $display("test lanes done");
    endtask

    task automatic t_desel();
        cap_q.delete();
        m.cyc(1'b0, 1'b0, 21'h3, 21'h3, 18'h0, 18'h0, 2'h0, 2'h0);
        m.idle(3);
        chk(cap_q.size() == 0 && q_oe === 1'b0, "no read output");
        rd1(21'h3, 2, 18'h2A5FF, 18'h0005A);
        $display("test deselect done");
    endtask

    task automatic t_b2b();
        int c;
        m.cyc(1'b0, 1'b1, 21'h0, 21'h5, 18'h12345, 18'h0ABCD, 2'h0, 2'h0);
        m.idle(2);
        cap_q.delete();
        cap_k.delete();
        m.cyc(1'b1, 1'b0, 21'h3, 21'h0, 18'h0, 18'h0, 2'h3, 2'h3);
        c = m.cmd_k;
        m.cyc(1'b1, 1'b0, 21'h5, 21'h0, 18'h0, 18'h0, 2'h3, 2'h3);
        m.idle(4);
        exp2(0, c + 2, 18'h2A5FF, 18'h0005A);
        exp2(2, c + 3, 18'h12345, 18'h0ABCD);
        chk(q_oe === 1'b0, "q released after bursts");
        $display("test back_to_back done");
    endtask

    task automatic t_pll();
        m.mode(1'b0, 1'b1);
        rd1(21'h5, 1, 18'h12345, 18'h0ABCD);
        m.mode(1'b1, 1'b1);
        $display("test pll_off done");
    endtask

    task automatic t_fifo();
        apb(1'b1, SP_REG_CTRL, 32'h1, rv, re);
        for (int i = 0; i < 5; i++) begin
            m.cyc(1'b0, 1'b1, 21'h0, 21'(8 + i), 18'(i), 18'(16 + i),
                2'h0, 2'h0);
        end
        m.idle(1);
        apb(1'b0, SP_REG_STATUS, 32'h0, rv, re);
        chk(rv[3:2] === 2'b01, "fifo full, overflow set");
        apb(1'b1, SP_REG_CTRL, 32'h0, rv, re);
        m.idle(2);
        apb(1'b0, SP_REG_STATUS, 32'h0, rv, re);
        chk(rv[3:2] === 2'b11, "fifo drained, overflow kept");
        apb(1'b1, SP_REG_STATUS, 32'h4, rv, re);
        apb(1'b0, SP_REG_STATUS, 32'h0, rv, re);
        chk(rv[3:2] === 2'b10, "overflow cleared");
        rd1(21'hB, 2, 18'h3, 18'h13);
        apb(1'b0, 8'h20, 32'h0, rv, re);
        chk(re === 1'b1 && rv === 32'h0, "unmapped address refused");
        $display("test fifo_apb done");
    endtask

    initial begin
        repeat (9) @(posedge mclk);
        chk(term_hi === 1'b1 && q_oe === 1'b0 && pready === 1'b0, "reset");
        @(posedge mclk);
        reset <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(term_hi === 1'b0, "low range latched");
        m.mode(1'b1, 1'b1);
        repeat (3) @(posedge mclk);
        chk(term_hi === 1'b0, "range kept after power-up");
        apb(1'b0, SP_REG_STATUS, 32'h0, rv, re);
        chk(rv === 32'h0000000A, "status after reset");
        $display("test power_up done");
        m.start();
        m.idle(2);
        t_wr_rd();
        t_lanes();
        t_desel();
        t_b2b();
        t_pll();
        t_fifo();
        end_sim();
    end
endmodule
